/* File: psf_board.sv */
/*
 board model: pad level of each port pin.
 assumes the block drives a pad while its enable is high, else the board level.
*/
`timescale 1ns/1ns
module psf_board (
    input wire [7:0] a_out,
    input wire [7:0] a_oe,
    input wire [7:0] b_out,
    input wire [7:0] b_oe,
    input wire [7:0] ext_a,
    input wire [7:0] ext_b,
    output wire [7:0] a_pin,
    output wire [7:0] b_pin
);
    // a driven pad shows the drive, others the board level
    assign a_pin = (a_oe & a_out) | (~a_oe & ext_a);
    assign b_pin = (b_oe & b_out) | (~b_oe & ext_b);
endmodule // psf_board

/* File: psf_defs.vh */
/*
 holds register offsets, field positions, reset values and codes for the
 port slew and pin function block. assumes inclusion by bare name.
*/
`ifndef PSF_DEFS_VH
`define PSF_DEFS_VH

`define PSF_ADDR_W 4
`define PSF_OFF_SLEW 4'h0
`define PSF_OFF_PORT_A_FUNCTION_SELECT_0 4'h1
`define PSF_OFF_PORT_A_FUNCTION_SELECT_1 4'h2
`define PSF_OFF_PORT_B_FUNCTION_SELECT_0 4'h3
`define PSF_OFF_PORT_B_FUNCTION_SELECT_1 4'h4
`define PSF_OFF_PA_DATA 4'h5
`define PSF_OFF_PA_DIR 4'h6
`define PSF_OFF_PB_DATA 4'h7
`define PSF_OFF_PB_DIR 4'h8
`define PSF_OFF_PA_WAKE 4'h9
`define PSF_OFF_BITOP 4'ha
`define PSF_OFF_MODE 4'hb
`define PSF_OFF_PA_PIN 4'hc
`define PSF_OFF_PB_PIN 4'hd

`define PSF_FSEL_RST 8'h00
`define PSF_SLEW_RST 8'h00
`define PSF_PORT_RST 8'hff
`define PSF_WAKE_RST 8'h00
`define PSF_PORT_A_FUNCTION_SELECT_0_MASK 8'h0c
`define PSF_PORT_A_FUNCTION_SELECT_1_MASK 8'h0c
`define PSF_PORT_B_FUNCTION_SELECT_0_MASK 8'h0f
`define PSF_PORT_B_FUNCTION_SELECT_1_MASK 8'hc0
`define PSF_PB_MASK 8'h83

`define PSF_FN_ALT 2'b01
`define PSF_A1_LO 2
`define PSF_A5_LO 2
`define PSF_B1_LO 2
`define PSF_B0_LO 0
`define PSF_B7_LO 6

// bit operation register: [3] set(1)/clear(0), [2:0] bit index, [7:4] target
`define PSF_BITOP_SET 3
`define PSF_BITOP_TGT_PA_DATA 4'h0
`define PSF_BITOP_TGT_PA_DIR 4'h1
`define PSF_BITOP_TGT_PB_DATA 4'h2
`define PSF_BITOP_TGT_PB_DIR 4'h3

`define PSF_RD_UNMAPPED 32'h00000000
`define PSF_RD_ZERO 8'h00

`endif

/* File: psf_pin_mux.v */
/*
 port slew rate selection, pin-shared function multiplexer, port data and
 direction registers, bit set/clear and port a wake-up.
 assumes an avalon-mm master on clk_sys and pads driven via out/oe signals.
*/
`timescale 1ns/1ns
`include "psf_defs.vh"
//
// Operation
// - slew applies only to cmos outputs
// - four two-bit slew fields, reset zero
// - a1 field 01 selects low voltage input
// - a5 field 01 drives inverted timer1
// - b1 field 01 drives inverted timer0
// - b0 field 01 drives timer0
// - b7 field 01 drives timer1
// - function fields reset zero, unimplemented read zero
// - data and direction reset high
// - bit set/clear is read-modify-write
// - port a falling edge wakes sleep
// - per pin wake enable, gpio input only
// - direction 1 input, 0 output reading latch
// - inverted timer output complements normal
module psf_pin_mux (
    input wire clk_sys,
    input wire reset,
    input wire [`PSF_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [7:0] port_a_in,
    input wire [7:0] port_b_in,
    input wire timer0_output,
    input wire timer1_output,
    output reg [7:0] port_a_out_q,
    output reg [7:0] port_a_oe_q,
    output reg [7:0] port_b_out_q,
    output reg [7:0] port_b_oe_q,
    output reg [7:0] port_a_slew_q,
    output reg [7:0] port_b_slew_q,
    output reg low_voltage_detector_input_q,
    output reg wake_q
);
    reg [7:0] slew_q;
    reg [7:0] port_a_function_select_0_q;
    reg [7:0] port_a_function_select_1_q;
    reg [7:0] port_b_function_select_0_q;
    reg [7:0] port_b_function_select_1_q;
    reg [7:0] pa_data_q;
    reg [7:0] pa_dir_q;
    reg [7:0] pb_data_q;
    reg [7:0] pb_dir_q;
    reg [7:0] pa_wake_q;
    reg low_power_q;
    reg [7:0] pa_s1_q;
    reg [7:0] pa_s2_q;
    reg [7:0] pb_s1_q;
    reg [7:0] pb_s2_q;
    reg ack_q;
    reg [7:0] rd_d;
    reg [7:0] rmw_d;
    reg [7:0] rmw_src;
    wire wake_pulse;
    wire req;
    wire wr_en;
    wire a1_alt;
    wire a5_alt;
    wire b0_alt;
    wire b1_alt;
    wire b7_alt;
    wire timer0_inv;
    wire timer1_inv;
    wire [7:0] pa_alt;
    wire [7:0] pb_alt;
    wire [7:0] pa_alt_val;
    wire [7:0] pb_alt_val;
    wire [7:0] pa_gpio_in;
    wire [3:0] bit_tgt;
    wire [2:0] bit_idx;
    wire take;
    wire [7:0] a1_lvd;
    wire [7:0] pa_cmos_out;
    wire [7:0] pb_cmos_out;
    wire [7:0] pa_slew_grp;
    wire [7:0] pb_slew_grp;
    wire [7:0] port_a_out_d;
    wire [7:0] port_b_out_d;
    wire low_voltage_detector_input_d;

    // field equals the alternate function code
    function is_alt;
        input [1:0] field;
        begin
            is_alt = (field == `PSF_FN_ALT);
        end
    endfunction

    // port read: pin level for inputs, latch for outputs
    function [7:0] port_view;
        input [7:0] dir;
        input [7:0] pin;
        input [7:0] latch;
        begin
            port_view = (dir & pin) | (~dir & latch);
        end
    endfunction

    // mask a group's slew bits with the pins that are driven
    function [7:0] slew_gate;
        input [7:0] group_mask;
        input [7:0] cmos_out;
        begin
            slew_gate = group_mask & cmos_out;
        end
    endfunction

    assign req = avs_read | avs_write;
    // a new request is taken while no answer is pending
    assign take = req & ~ack_q;
    // a write lands on the edge at which the master sees waitrequest low
    assign wr_en = avs_write & ack_q & avs_byteenable[0];
    assign bit_tgt = avs_writedata[7:4];
    assign bit_idx = avs_writedata[2:0];

    assign a1_alt = is_alt(port_a_function_select_0_q[`PSF_A1_LO+1:`PSF_A1_LO]);
    assign a5_alt = is_alt(port_a_function_select_1_q[`PSF_A5_LO+1:`PSF_A5_LO]);
    assign b1_alt = is_alt(port_b_function_select_0_q[`PSF_B1_LO+1:`PSF_B1_LO]);
    assign b0_alt = is_alt(port_b_function_select_0_q[`PSF_B0_LO+1:`PSF_B0_LO]);
    assign b7_alt = is_alt(port_b_function_select_1_q[`PSF_B7_LO+1:`PSF_B7_LO]);
    assign timer0_inv = ~timer0_output;
    assign timer1_inv = ~timer1_output;

    // pins taken by a timer output
    assign pa_alt = {2'b00, a5_alt, 5'b00000};
    assign pb_alt = {b7_alt, 5'b00000, b1_alt, b0_alt};
    assign pa_alt_val = {2'b00, timer1_inv, 5'b00000};
    assign pb_alt_val = {timer1_output, 5'b00000, timer0_inv, timer0_output};
    // pin a1 serves the detector input while its field selects it
    assign a1_lvd = {6'b000000, a1_alt, 1'b0};
    // general purpose inputs only; a1 as detector input is not one
    assign pa_gpio_in = pa_dir_q & ~pa_alt & ~a1_lvd;
    // driven pins: timer outputs, and cmos outputs not taken by the detector
    assign pa_cmos_out = pa_alt | (~pa_dir_q & ~a1_lvd);
    assign pb_cmos_out = (pb_alt | ~pb_dir_q) & `PSF_PB_MASK;
    // low bit of each group's slew code spread over the group's pins
    assign pa_slew_grp = {{4{slew_q[2]}}, {4{slew_q[0]}}};
    assign pb_slew_grp = {slew_q[6], 5'b00000, {2{slew_q[4]}}};
    // pad drive: timer pins regardless of direction, others from the data latch
    assign port_a_out_d = (pa_alt & pa_alt_val) | (~pa_alt & pa_data_q);
    assign port_b_out_d = ((pb_alt & pb_alt_val) | (~pb_alt & pb_data_q)) & `PSF_PB_MASK;
    assign low_voltage_detector_input_d = a1_alt & pa_s2_q[1];

    // pin synchronisers
    always @(posedge clk_sys) begin
        if (reset) begin
            pa_s1_q <= `PSF_PORT_RST;
            pa_s2_q <= `PSF_PORT_RST;
            pb_s1_q <= `PSF_PORT_RST;
            pb_s2_q <= `PSF_PORT_RST;
        end else begin
            pa_s1_q <= port_a_in;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= port_b_in;
            pb_s2_q <= pb_s1_q;
        end
    end

    // source of a bit set/clear
    always @* begin
        if (bit_tgt == `PSF_BITOP_TGT_PA_DATA) begin
            rmw_src = port_view(pa_dir_q, pa_s2_q, pa_data_q);
        end else if (bit_tgt == `PSF_BITOP_TGT_PA_DIR) begin
            rmw_src = pa_dir_q;
        end else if (bit_tgt == `PSF_BITOP_TGT_PB_DATA) begin
            rmw_src = port_view(pb_dir_q, pb_s2_q, pb_data_q) & `PSF_PB_MASK;
        end else begin
            rmw_src = pb_dir_q;
        end
        rmw_d = rmw_src;
        rmw_d[bit_idx] = avs_writedata[`PSF_BITOP_SET];
    end

    // register writes
    always @(posedge clk_sys) begin
        if (reset) begin
            slew_q <= `PSF_SLEW_RST;
            port_a_function_select_0_q <= `PSF_FSEL_RST;
            port_a_function_select_1_q <= `PSF_FSEL_RST;
            port_b_function_select_0_q <= `PSF_FSEL_RST;
            port_b_function_select_1_q <= `PSF_FSEL_RST;
            pa_data_q <= `PSF_PORT_RST;
            pa_dir_q <= `PSF_PORT_RST;
            pb_data_q <= `PSF_PORT_RST & `PSF_PB_MASK;
            pb_dir_q <= `PSF_PORT_RST & `PSF_PB_MASK;
            pa_wake_q <= `PSF_WAKE_RST;
        end else if (wr_en) begin
            if (avs_address == `PSF_OFF_SLEW) begin
                slew_q <= avs_writedata[7:0];
            end else if (avs_address == `PSF_OFF_PORT_A_FUNCTION_SELECT_0) begin
                port_a_function_select_0_q <= avs_writedata[7:0] & `PSF_PORT_A_FUNCTION_SELECT_0_MASK;
            end else if (avs_address == `PSF_OFF_PORT_A_FUNCTION_SELECT_1) begin
                port_a_function_select_1_q <= avs_writedata[7:0] & `PSF_PORT_A_FUNCTION_SELECT_1_MASK;
            end else if (avs_address == `PSF_OFF_PORT_B_FUNCTION_SELECT_0) begin
                port_b_function_select_0_q <= avs_writedata[7:0] & `PSF_PORT_B_FUNCTION_SELECT_0_MASK;
            end else if (avs_address == `PSF_OFF_PORT_B_FUNCTION_SELECT_1) begin
                port_b_function_select_1_q <= avs_writedata[7:0] & `PSF_PORT_B_FUNCTION_SELECT_1_MASK;
            end else if (avs_address == `PSF_OFF_PA_DATA) begin
                pa_data_q <= avs_writedata[7:0];
            end else if (avs_address == `PSF_OFF_PA_DIR) begin
                pa_dir_q <= avs_writedata[7:0];
            end else if (avs_address == `PSF_OFF_PB_DATA) begin
                pb_data_q <= avs_writedata[7:0] & `PSF_PB_MASK;
            end else if (avs_address == `PSF_OFF_PB_DIR) begin
                pb_dir_q <= avs_writedata[7:0] & `PSF_PB_MASK;
            end else if (avs_address == `PSF_OFF_PA_WAKE) begin
                pa_wake_q <= avs_writedata[7:0];
            end else if (avs_address == `PSF_OFF_BITOP) begin
                // whole port written back with one bit altered
                if (bit_tgt == `PSF_BITOP_TGT_PA_DATA) begin
                    pa_data_q <= rmw_d;
                end else if (bit_tgt == `PSF_BITOP_TGT_PA_DIR) begin
                    pa_dir_q <= rmw_d;
                end else if (bit_tgt == `PSF_BITOP_TGT_PB_DATA) begin
                    pb_data_q <= rmw_d & `PSF_PB_MASK;
                end else if (bit_tgt == `PSF_BITOP_TGT_PB_DIR) begin
                    pb_dir_q <= rmw_d & `PSF_PB_MASK;
                end
            end
        end
    end

    // sleep/idle mode bit: a wake clears it, winning over a write in the same cycle
    always @(posedge clk_sys) begin
        if (reset) begin
            low_power_q <= 1'b0;
        end else if (wake_pulse) begin
            low_power_q <= 1'b0;
        end else if (wr_en && avs_address == `PSF_OFF_MODE) begin
            low_power_q <= avs_writedata[0];
        end
    end

    // read decode
    always @* begin
        if (avs_address == `PSF_OFF_SLEW) begin
            rd_d = slew_q;
        end else if (avs_address == `PSF_OFF_PORT_A_FUNCTION_SELECT_0) begin
            rd_d = port_a_function_select_0_q;
        end else if (avs_address == `PSF_OFF_PORT_A_FUNCTION_SELECT_1) begin
            rd_d = port_a_function_select_1_q;
        end else if (avs_address == `PSF_OFF_PORT_B_FUNCTION_SELECT_0) begin
            rd_d = port_b_function_select_0_q;
        end else if (avs_address == `PSF_OFF_PORT_B_FUNCTION_SELECT_1) begin
            rd_d = port_b_function_select_1_q;
        end else if (avs_address == `PSF_OFF_PA_DATA) begin
            rd_d = port_view(pa_dir_q, pa_s2_q, pa_data_q);
        end else if (avs_address == `PSF_OFF_PA_DIR) begin
            rd_d = pa_dir_q;
        end else if (avs_address == `PSF_OFF_PB_DATA) begin
            rd_d = port_view(pb_dir_q, pb_s2_q, pb_data_q) & `PSF_PB_MASK;
        end else if (avs_address == `PSF_OFF_PB_DIR) begin
            rd_d = pb_dir_q;
        end else if (avs_address == `PSF_OFF_PA_WAKE) begin
            rd_d = pa_wake_q;
        end else if (avs_address == `PSF_OFF_MODE) begin
            rd_d = {7'h00, low_power_q};
        end else if (avs_address == `PSF_OFF_PA_PIN) begin
            rd_d = pa_s2_q;
        end else if (avs_address == `PSF_OFF_PB_PIN) begin
            rd_d = pb_s2_q & `PSF_PB_MASK;
        end else begin
            rd_d = `PSF_RD_ZERO;
        end
    end

    // bus handshake: one wait cycle, answer on the second edge
    always @(posedge clk_sys) begin
        if (reset) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `PSF_RD_UNMAPPED;
        end else begin
            ack_q <= take;
            avs_waitrequest <= ~take;
            if (avs_read & take) begin
                avs_readdata <= {24'h000000, rd_d};
            end
        end
    end

    // pin drivers and slew, from the registered configuration
    always @(posedge clk_sys) begin
        if (reset) begin
            port_a_out_q <= `PSF_PORT_RST;
            port_a_oe_q <= 8'h00;
            port_b_out_q <= `PSF_PORT_RST & `PSF_PB_MASK;
            port_b_oe_q <= 8'h00;
            port_a_slew_q <= 8'h00;
            port_b_slew_q <= 8'h00;
            low_voltage_detector_input_q <= 1'b0;
        end else begin
            // registered one cycle after the configuration registers
            port_a_out_q <= port_a_out_d;
            port_a_oe_q <= pa_cmos_out;
            port_b_out_q <= port_b_out_d;
            port_b_oe_q <= pb_cmos_out;
            low_voltage_detector_input_q <= low_voltage_detector_input_d;
            // slew bit per pin, only on pins that are driven
            port_a_slew_q <= slew_gate(pa_slew_grp, pa_cmos_out);
            port_b_slew_q <= slew_gate(pb_slew_grp, pb_cmos_out);
        end
    end

    psf_wake_detect #(
        .WIDTH(8)
    ) u_wake (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_level(pa_s2_q),
        .wake_enable(pa_wake_q),
        .is_gpio_input(pa_gpio_in),
        .low_power(low_power_q),
        .wake_q(wake_pulse)
    );

    // one-cycle wake pulse towards the core
    always @(posedge clk_sys) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_pulse;
        end
    end
endmodule // psf_pin_mux

/* File: psf_pin_mux_asserts.sv */
/*
 port-level checker for psf_pin_mux, bound to every instance.
 assumes a master that holds each request until waitrequest is seen low.
*/
`timescale 1ns/1ns
module psf_pin_mux_asserts (
    input wire clk_sys,
    input wire reset,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [7:0] port_a_out_q,
    input wire [7:0] port_a_oe_q,
    input wire [7:0] port_b_oe_q,
    input wire [7:0] port_a_slew_q,
    input wire [7:0] port_b_slew_q,
    input wire low_voltage_detector_input_q,
    input wire wake_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_req_acked: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered on the next edge");
    a_rdata_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > 4'hd |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_wake_pulse: assert property (wake_q |=> !wake_q)
        else $error("wake pulse longer than one cycle");
    a_slew_cmos: assert property (
        ((port_a_slew_q & ~port_a_oe_q) | (port_b_slew_q & ~port_b_oe_q)) == 8'h0)
        else $error("slew applied to a pin that is not driven");
    a_portb_absent: assert property (((port_b_oe_q | port_b_slew_q) & 8'h7c) == 8'h0)
        else $error("absent port b pin driven");
    a_reset_state: assert property ($fell(reset) |->
        port_a_out_q == 8'hff && port_a_oe_q == 8'h0 && port_b_oe_q == 8'h0)
        else $error("pin state after reset wrong");
    a_cfg_timing: assert property (
        $changed({port_a_oe_q, port_b_oe_q, port_a_slew_q, port_b_slew_q})
        |-> $past(avs_write, 2) && !$past(avs_waitrequest, 2))
        else $error("pin configuration changed without a write");
    c_wake: cover property (wake_q);
    c_lvd: cover property (low_voltage_detector_input_q);
    c_slew: cover property (port_a_slew_q == 8'hff);
endmodule // psf_pin_mux_asserts

bind psf_pin_mux psf_pin_mux_asserts u_chk (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_a_out_q(port_a_out_q), .port_a_oe_q(port_a_oe_q), .port_b_oe_q(port_b_oe_q),
    .port_a_slew_q(port_a_slew_q), .port_b_slew_q(port_b_slew_q),
    .low_voltage_detector_input_q(low_voltage_detector_input_q), .wake_q(wake_q));

/* File: psf_pin_mux_tb.sv */
/*
 self-checking testbench for psf_pin_mux with the board model.
 assumes a 100 MHz clock and avalon-mm register access.
*/
`timescale 1ns/1ns
module psf_pin_mux_tb;
    reg clk_sys = 0, reset = 1, avs_read = 0, avs_write = 0, t0 = 0, t1 = 0, t;
    reg [3:0] avs_address = 0;
    reg [31:0] avs_writedata = 0, rd;
    reg [7:0] ext_a = 8'hff, ext_b = 8'hff;
    reg [1:0] c;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, lvd, wake_q;
    wire [7:0] ao, aoe, bo, boe, as, bs, ai, bi;
    int bad_count = 0, comparisons = 0, i, n;
    psf_pin_mux dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_a_in(ai), .port_b_in(bi), .timer0_output(t0), .timer1_output(t1),
        .port_a_out_q(ao), .port_a_oe_q(aoe), .port_b_out_q(bo), .port_b_oe_q(boe),
        .port_a_slew_q(as), .port_b_slew_q(bs), .low_voltage_detector_input_q(lvd),
        .wake_q(wake_q));
    psf_board brd (.a_out(ao), .a_oe(aoe), .b_out(bo), .b_oe(boe), .ext_a(ext_a),
        .ext_b(ext_b), .a_pin(ai), .b_pin(bi));
    task complete_run;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
        acc(0, a, 8'h0);
        chk(nm, rd, {24'h0, e});
    endtask
    task fsel(input logic [1:0] k);
        acc(1, 4'h1, {4'h0, k, 2'b00});
        acc(1, 4'h2, {4'h0, k, 2'b00});
        acc(1, 4'h3, {4'h0, k, k});
        acc(1, 4'h4, {k, 6'h0});
        repeat (6) @(posedge clk_sys);
    endtask
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        rdc("slew", 4'h0, 8'h00);
        for (i = 1; i < 5; i++) rdc("fsel", i, 8'h00);
        rdc("pa_dir", 4'h6, 8'hff);
        rdc("pb_dir", 4'h8, 8'h83);
        rdc("unmapped", 4'he, 8'h00);
        for (i = 1; i < 5; i++) begin
            acc(1, i, 8'hff);
            rdc("fsel_rb", i, i < 3 ? 8'h0c : i == 3 ? 8'h0f : 8'hc0);
        end
        $display("test reset and read-back done");
        for (i = 0; i < 8; i++) begin
            c = i[2:1];
            t = i[0];
            fsel(c);
            {t1, t0} <= {t, t};
            ext_a[1] <= t;
            repeat (4) @(posedge clk_sys);
            chk("b_oe", boe, c == 2'b01 ? 8'h83 : 8'h00);
            chk("b_out", bo & 8'h83, c == 2'b01 ? {t, 5'h0, ~t, t} : 8'h83);
            chk("a5", {aoe[5], ao[5]}, c == 2'b01 ? {1'b1, ~t} : 2'b01);
            chk("lvd", lvd, c == 2'b01 && t);
            {t1, t0} <= 2'b00;
        end
        fsel(2'b00);
        $display("test function select done");
        acc(1, 4'h0, 8'h55);
        rdc("slew_rb", 4'h0, 8'h55);
        chk("slew_in", {as, bs}, 16'h0);
        acc(1, 4'h6, 8'h00);
        acc(1, 4'h8, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("a_drive", {aoe, ao}, 16'hffff);
        chk("slew_out", {as, bs}, 16'hff83);
        acc(1, 4'h0, 8'haa);
        repeat (2) @(posedge clk_sys);
        chk("slew_lvl2", {as, bs}, 16'h0);
        $display("test slew done");
        ext_a <= 8'hfe;
        acc(1, 4'ha, 8'h18);
        repeat (3) @(posedge clk_sys);
        acc(1, 4'ha, 8'h02);
        rdc("pa_dir", 4'h6, 8'h01);
        rdc("pa_rd", 4'h5, 8'hfa);
        acc(1, 4'h6, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("rmw_latch", ao, 8'hfa);
        rdc("pa_pin", 4'hc, 8'hfa);
        acc(1, 4'ha, 8'h39);
        rdc("pb_dir_rmw", 4'h8, 8'h02);
        acc(1, 4'ha, 8'h20);
        rdc("pb_rd", 4'h7, 8'h82);
        rdc("pb_pin", 4'hd, 8'h82);
        $display("test bit operations done");
        acc(1, 4'h6, 8'hff);
        ext_a <= 8'hff;
        acc(1, 4'h9, 8'h08);
        acc(1, 4'hb, 8'h01);
        ext_a <= 8'hfb;
        n = 0;
        repeat (8) @(posedge clk_sys) n += (wake_q === 1'b1);
        chk("wake_off", n, 0);
        ext_a <= 8'hf3;
        n = 0;
        repeat (8) @(posedge clk_sys) n += (wake_q === 1'b1);
        chk("wake_on", n, 1);
        rdc("mode", 4'hb, 8'h00);
        $display("test wake done");
        complete_run;
    end
endmodule // psf_pin_mux_tb

/* File: psf_wake_detect.v */
/*
 port a falling edge wake detector.
 assumes synchronised pin levels on the same clock.
*/
`timescale 1ns/1ns
module psf_wake_detect #(
    parameter WIDTH = 8
) (
    input wire clk_sys,
    input wire reset,
    input wire [WIDTH-1:0] pin_level,
    input wire [WIDTH-1:0] wake_enable,
    input wire [WIDTH-1:0] is_gpio_input,
    input wire low_power,
    output reg wake_q
);
    reg [WIDTH-1:0] prev_q;
    wire [WIDTH-1:0] fall;

    assign fall = prev_q & ~pin_level;

    always @(posedge clk_sys) begin
        if (reset) begin
            prev_q <= {WIDTH{1'b1}};
            wake_q <= 1'b0;
        end else begin
            prev_q <= pin_level;
            // any enabled general purpose input falling while asleep
            wake_q <= low_power & (|(fall & wake_enable & is_gpio_input));
        end
    end
endmodule // psf_wake_detect
